/* test/contact_bank.sv */
// Model of the switch contacts wired to the input terminals.
// Assumes a closed contact pulls its pin high and that a change may bounce.
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Contact bank
// ------------------------------------------------------------
module contact_bank (
	// Clock and controls.
	input wire logic mclk_i,
	input wire logic [10:0] closed_i,
	input wire logic bounce_i,
	// Terminal levels.
	output logic [10:0] terminal_o
);
	logic [2:0] chatter;
	// A change chatters for a few cycles before it settles, which the filter must ride out.
	always @(posedge mclk_i) begin
		if (bounce_i && closed_i != terminal_o && chatter == 3'h0) begin
			chatter <= 3'h5;
		end else if (chatter != 3'h0) begin
			chatter <= chatter - 3'h1;
		end
		terminal_o <= (chatter > 3'h1) ? ~terminal_o : closed_i;
	end
	initial begin
		chatter = 3'h0;
		terminal_o = 11'h000;
	end
endmodule : contact_bank
`default_nettype wire

/* test/tb_io_settings.sv */
// Self-checking bench for the settings block.
// Assumes one clock, a classic Wishbone slave with one-cycle ack, and CHECK_CYCLES of 10.
`timescale 1ns/1ns
`default_nettype none
module tb_io_settings;
	import io_settings_pkg::*;
	logic mclk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fitted, mstep, overheat, bounce, irq_o;
	logic motor_trip_o, drive_trip_o, process_control_o;
	logic [7:0] wb_adr_i, mtemp, ttemp;
	logic [31:0] wb_dat_i, wb_dat_o, rng;
	logic [10:0] closed, pins, input_active_o;
	logic [15:0] relay_select_o;
	logic [3:0] ol_index;
	logic [31:0] expq[$];
	int fails, check_count, cycles;
	// ------------------------------------------------------------
	// Clock, partner and design
	// ------------------------------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	contact_bank contacts (.mclk_i(mclk_i), .closed_i(closed), .bounce_i(bounce), .terminal_o(pins));
	io_settings #(.CHECK_CYCLES(10)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .terminal_i(pins), .expansion_fitted_i(fitted),
		.multi_step_active_i(mstep), .open_loop_terminal_i(ol_index), .motor_temperature_i(mtemp),
		.thermistor_temperature_i(ttemp), .drive_overheat_i(overheat), .input_active_o(input_active_o),
		.motor_trip_o(motor_trip_o), .drive_trip_o(drive_trip_o), .process_control_o(process_control_o),
		.relay_select_o(relay_select_o), .irq_o(irq_o));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Compares one value and counts the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One classic cycle; a read leaves its expected word for the monitor.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge mclk_i);
		if (!we) expq.push_back(dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= we ? dat : 32'h0;
		do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask : wait_cyc
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xorshift
	// Read data is taken at the ack edge and checked against the oldest note.
	always @(posedge mclk_i) begin
		if (wb_ack_o === 1'b1 && !wb_we_i && expq.size() > 0) check(wb_dat_o, expq.pop_front());
	end
	// Cuts a hang short.
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{reset_i, wb_cyc_i, wb_stb_i, wb_we_i, fitted, mstep, overheat, bounce} = 8'h80;
		{wb_adr_i, wb_dat_i, closed, ol_index, mtemp, ttemp} = '0;
		{fails, check_count, cycles} = '0;
		rng = 32'h8765;
		wait_cyc(8);
		reset_i <= 1'b0;
		wb(1'b0, OFS_POLARITY, 32'h0);
		wb(1'b0, OFS_CHECK_TIME, 32'h1);
		wb(1'b0, OFS_OH_SELECT, 32'h7);
		wb(1'b0, OFS_TRIP_TEMP, 32'h6e);
		wb(1'b0, 8'h24, 32'h0);
		check(process_control_o, 32'h0);
		$display("Reset values done");
		wb(1'b1, OFS_POLARITY, 32'h7ff);
		wb(1'b0, OFS_POLARITY, 32'h0ff);
		fitted <= 1'b1;
		wait_cyc(4);
		wb(1'b1, OFS_POLARITY, 32'h7ff);
		wb(1'b0, OFS_POLARITY, 32'h7ff);
		wait_cyc(6);
		wb(1'b0, OFS_INPUT_STATE, 32'h7ff);
		wb(1'b1, OFS_POLARITY, 32'h0);
		$display("Polarity done");
		mstep <= 1'b1;
		bounce <= 1'b1;
		wait_cyc(8);
		closed <= 11'h001;
		wait_cyc(14);
		check(input_active_o, 32'h0);
		wait_cyc(14);
		check(input_active_o, 32'h1);
		$display("Checking time done");
		wb(1'b1, OFS_OH_SELECT, 32'h1);
		rng = xorshift(rng);
		mtemp <= 8'(rng % 110);
		wait_cyc(4);
		check(motor_trip_o, 32'h0);
		mtemp <= 8'h6e;
		wait_cyc(4);
		check(motor_trip_o, 32'h1);
		wb(1'b1, OFS_OH_SELECT, 32'h5);
		wait_cyc(4);
		check(motor_trip_o, 32'h0);
		ttemp <= 8'h6e;
		wait_cyc(4);
		check(motor_trip_o, 32'h1);
		wb(1'b1, OFS_OH_SELECT, 32'h3);
		ttemp <= 8'h00;
		wait_cyc(4);
		check(motor_trip_o, 32'h1);
		mtemp <= 8'h00;
		wb(1'b1, OFS_OH_SELECT, 32'h0);
		overheat <= 1'b1;
		wait_cyc(4);
		check(drive_trip_o, 32'h1);
		wb(1'b0, OFS_IRQ_STATUS, 32'h7);
		overheat <= 1'b0;
		wb(1'b1, OFS_IRQ_MASK, 32'h7);
		wait_cyc(2);
		check(irq_o, 32'h1);
		wb(1'b1, OFS_IRQ_STATUS, 32'h7);
		wb(1'b0, OFS_IRQ_STATUS, 32'h0);
		check(irq_o, 32'h0);
		$display("Overheat done");
		wb(1'b1, OFS_APP_CTRL, 32'h21);
		wb(1'b0, OFS_RELAY_SEL, 32'h9999);
		wb(1'b1, OFS_RELAY_SEL, 32'h1234);
		wb(1'b0, OFS_RELAY_SEL, 32'h1299);
		wb(1'b1, OFS_APP_CTRL, 32'h0);
		wb(1'b0, OFS_RELAY_SEL, 32'h1299);
		$display("Relays done");
		ol_index <= 4'h3;
		wb(1'b1, OFS_APP_CTRL, 32'h2);
		wait_cyc(3);
		check(process_control_o, 32'h1);
		closed <= 11'h009;
		wait_cyc(30);
		check(process_control_o, 32'h0);
		closed <= 11'h001;
		wait_cyc(30);
		check(process_control_o, 32'h1);
		$display("Process control done");
		end_of_test();
	end
endmodule : tb_io_settings
`default_nettype wire

/* verilog/io_settings.sv */
// Input polarity, validity filter, overheat select and relay assignment logic.
// Assumes input pins are asynchronous and a Wishbone classic master on mclk_i.
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - An 11-bit polarity register holds open (0) or closed (1) contact sense, base inputs in bits 0-7, expansion in 8-10.
// - Polarity bits 8 to 10 can be written only while the expansion board is fitted.
// - With multi-step selection active, an input change is accepted only after the checking time, 1 ms by default.
// - Drive overheat protection trips at all times regardless of the select bits.
// - With select bit 1 set, a motor trip occurs once motor temperature reaches the trip temperature, 110 C default.
// - Select bit 2 is reserved and inert, and bit 3 enables the external thermistor.
// - The three overheat select bits reset to all ones.
// - Entering multi-motor mode sets all four relay selections to the multi-motor function.
// - In multi-motor mode with fewer than four auxiliary motors, unused relays may be assigned freely.
// - Leaving multi-motor mode leaves the relay selections unchanged.
// - An active open-loop input switches process control to manual, returning when it goes inactive.
// - Process control runs only when its enable is set, default off.
module io_settings
	import io_settings_pkg::*;
#(
	parameter int CHECK_CYCLES = CYCLES_PER_MS
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic reset_i,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Terminal pins and board presence.
	input wire logic [NUM_INPUTS-1:0] terminal_i,
	input wire logic expansion_fitted_i,
	// Control inputs from the drive.
	input wire logic multi_step_active_i,
	input wire logic [3:0] open_loop_terminal_i,
	input wire logic [7:0] motor_temperature_i,
	input wire logic [7:0] thermistor_temperature_i,
	input wire logic drive_overheat_i,
	// Results.
	output logic [NUM_INPUTS-1:0] input_active_o,
	output logic motor_trip_o,
	output logic drive_trip_o,
	output logic process_control_o,
	output logic [NUM_RELAYS*RELAY_FN_W-1:0] relay_select_o,
	output logic irq_o
);

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	logic [NUM_INPUTS-1:0] input_contact_polarity;
	logic [7:0] input_validity_time;
	logic [2:0] overheat_trip_select;
	logic [7:0] motor_trip_temperature;
	logic multi_motor_mode;
	logic process_control_enable;
	logic [2:0] aux_motor_count;
	logic [NUM_INPUTS-1:0] sync1, sync2, filtered;
	logic [31:0] check_count;
	logic [IRQ_W-1:0] irq_status, irq_mask, irq_event;
	logic wr, rd;
	logic [1:0] fitted_sync;
	logic multi_step_q1, multi_step_q2;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Two stages for terminals, board presence and mode strobe.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			sync1 <= '0;
			sync2 <= '0;
			fitted_sync <= 2'h0;
			multi_step_q1 <= 1'b0;
			multi_step_q2 <= 1'b0;
		end else begin
			sync1 <= terminal_i;
			sync2 <= sync1;
			fitted_sync <= {fitted_sync[0], expansion_fitted_i};
			multi_step_q1 <= multi_step_active_i;
			multi_step_q2 <= multi_step_q1;
		end
	end

	// ------------------------------------------------------------
	// Validity filter
	// ------------------------------------------------------------
	// Polarity-corrected inputs; a change waits out the checking time when multi-step is active.
	logic [NUM_INPUTS-1:0] corrected;
	logic [31:0] check_limit;
	assign corrected = sync2 ^ input_contact_polarity;
	assign check_limit = 32'(input_validity_time) * 32'(CHECK_CYCLES);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			filtered <= '0;
			check_count <= 32'h0;
		end else if (corrected == filtered) begin
			check_count <= 32'h0;
		end else if (!multi_step_q2 || check_count + 32'h1 >= check_limit) begin
			filtered <= corrected;
			check_count <= 32'h0;
		end else begin
			check_count <= check_count + 32'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) input_active_o <= '0;
		else input_active_o <= filtered;
	end

	// ------------------------------------------------------------
	// Overheat and process control
	// ------------------------------------------------------------
	// Motor temperature source follows select bit 3; drive protection never gated.
	logic [7:0] motor_temp_sel;
	assign motor_temp_sel = overheat_trip_select[OH_THERM_BIT] ? thermistor_temperature_i : motor_temperature_i;

	// Motor trip condition, shared by the trip flop and its interrupt event.
	logic motor_trip_cond;
	assign motor_trip_cond = overheat_trip_select[OH_MOTOR_BIT] && motor_temp_sel >= motor_trip_temperature;

	// Open-loop terminal state; an index beyond the terminals never bypasses, so no unknown reaches the output.
	logic open_loop_active;
	assign open_loop_active = (int'(open_loop_terminal_i) < NUM_INPUTS) && filtered[open_loop_terminal_i];

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			motor_trip_o <= 1'b0;
			drive_trip_o <= 1'b0;
			process_control_o <= 1'b0;
		end else begin
			motor_trip_o <= motor_trip_cond;
			drive_trip_o <= drive_overheat_i;
			process_control_o <= process_control_enable && !open_loop_active;
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Writes to the configuration registers.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			input_contact_polarity <= POLARITY_RESET;
			input_validity_time <= CHECK_MS_RESET;
			overheat_trip_select <= OH_SELECT_RESET;
			motor_trip_temperature <= TRIP_TEMP_RESET;
			multi_motor_mode <= 1'b0;
			process_control_enable <= 1'b0;
			aux_motor_count <= 3'h0;
			irq_mask <= '0;
		end else if (wr) begin
			unique case (wb_adr_i)
				OFS_POLARITY: begin
					input_contact_polarity[NUM_BASE-1:0] <= wb_dat_i[7:0];
					if (fitted_sync[1] && wb_sel_i[1])
						input_contact_polarity[NUM_INPUTS-1:NUM_BASE] <= wb_dat_i[10:8];
				end
				OFS_CHECK_TIME: input_validity_time <= wb_dat_i[7:0];
				OFS_OH_SELECT: overheat_trip_select <= wb_dat_i[2:0];
				OFS_TRIP_TEMP: motor_trip_temperature <= wb_dat_i[7:0];
				OFS_APP_CTRL: begin
					multi_motor_mode <= wb_dat_i[APP_MULTI_BIT];
					process_control_enable <= wb_dat_i[APP_PROC_BIT];
					aux_motor_count <= wb_dat_i[APP_AUXCNT_LSB+:3];
				end
				OFS_IRQ_MASK: irq_mask <= wb_dat_i[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Relay selections: forced on entering multi-motor, else software owned.
	logic entering_multi;
	assign entering_multi = wr && wb_adr_i == OFS_APP_CTRL && wb_dat_i[APP_MULTI_BIT] && !multi_motor_mode;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			relay_select_o <= '0;
		end else if (entering_multi) begin
			relay_select_o <= {NUM_RELAYS{RELAY_FN_MULTI_MOTOR}};
		end else if (wr && wb_adr_i == OFS_RELAY_SEL) begin
			for (int i = 0; i < NUM_RELAYS; i++) begin
				// Relays in use by auxiliary motors stay locked while multi-motor runs.
				if (!multi_motor_mode || i >= int'(aux_motor_count))
					relay_select_o[i*RELAY_FN_W+:RELAY_FN_W] <= wb_dat_i[i*RELAY_FN_W+:RELAY_FN_W];
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Sticky status; a new event wins over a write-one clear.
	// Events are rising edges: a trip about to be raised, or a filtered input that just changed.
	assign irq_event[IRQ_MOTOR_TRIP] = motor_trip_cond && !motor_trip_o;
	assign irq_event[IRQ_DRIVE_TRIP] = drive_overheat_i && !drive_trip_o;
	assign irq_event[IRQ_INPUT_CHANGE] = input_active_o != filtered;

	always_ff @(posedge mclk_i) begin
		if (reset_i) irq_status <= '0;
		else if (wr && wb_adr_i == OFS_IRQ_STATUS) irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | irq_event;
		else irq_status <= irq_status | irq_event;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) irq_o <= 1'b0;
		else irq_o <= |(irq_status & irq_mask);
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	// One-cycle ack, read data registered; unmapped offsets read zero.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= rd;
			wb_dat_o <= 32'h0;
			if (rd) begin
				unique case (wb_adr_i)
					OFS_POLARITY: wb_dat_o <= 32'(input_contact_polarity);
					OFS_CHECK_TIME: wb_dat_o <= 32'(input_validity_time);
					OFS_OH_SELECT: wb_dat_o <= 32'(overheat_trip_select);
					OFS_TRIP_TEMP: wb_dat_o <= 32'(motor_trip_temperature);
					OFS_APP_CTRL: wb_dat_o <= 32'({aux_motor_count, 2'h0, process_control_enable, multi_motor_mode});
					OFS_RELAY_SEL: wb_dat_o <= 32'(relay_select_o);
					OFS_INPUT_STATE: wb_dat_o <= 32'(filtered);
					OFS_IRQ_STATUS: wb_dat_o <= 32'(irq_status);
					OFS_IRQ_MASK: wb_dat_o <= 32'(irq_mask);
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_oh_reset;
		@(posedge mclk_i) $fell(reset_i) |-> overheat_trip_select == 3'h7;
	endproperty
	a_oh_reset: assert property (p_oh_reset) else $error("overheat select not all ones after reset");

	property p_drive_trip;
		@(posedge mclk_i) disable iff (reset_i) drive_overheat_i |=> drive_trip_o;
	endproperty
	a_drive_trip: assert property (p_drive_trip) else $error("drive trip missed");

	property p_motor_trip;
		@(posedge mclk_i) disable iff (reset_i)
			(overheat_trip_select[0] && motor_temp_sel >= motor_trip_temperature) |=> motor_trip_o;
	endproperty
	a_motor_trip: assert property (p_motor_trip) else $error("motor trip missed");

	property p_motor_no_trip;
		@(posedge mclk_i) disable iff (reset_i) !overheat_trip_select[0] |=> !motor_trip_o;
	endproperty
	a_motor_no_trip: assert property (p_motor_no_trip) else $error("motor trip while disabled");

	property p_multi_relays;
		@(posedge mclk_i) disable iff (reset_i) entering_multi |=> relay_select_o == {4{RELAY_FN_MULTI_MOTOR}};
	endproperty
	a_multi_relays: assert property (p_multi_relays) else $error("relays not forced to multi-motor");

	property p_expansion_lock;
		@(posedge mclk_i) disable iff (reset_i) !fitted_sync[1] |=> $stable(input_contact_polarity[10:8]);
	endproperty
	a_expansion_lock: assert property (p_expansion_lock) else $error("expansion polarity changed without board");

	property p_proc_off;
		@(posedge mclk_i) disable iff (reset_i) !process_control_enable |=> !process_control_o;
	endproperty
	a_proc_off: assert property (p_proc_off) else $error("process control without enable");

	property p_open_loop;
		@(posedge mclk_i) disable iff (reset_i) open_loop_active |=> !process_control_o;
	endproperty
	a_open_loop: assert property (p_open_loop) else $error("process control during open loop");

	property p_filter_hold;
		@(posedge mclk_i) disable iff (reset_i)
			(multi_step_q2 && check_count + 32'h1 < check_limit && corrected != filtered) |=> $stable(filtered);
	endproperty
	a_filter_hold: assert property (p_filter_hold) else $error("input accepted before checking time");

	c_multi: cover property (@(posedge mclk_i) entering_multi);
	c_motor_trip: cover property (@(posedge mclk_i) $rose(motor_trip_o));
	c_filter: cover property (@(posedge mclk_i) multi_step_q2 && $changed(filtered));
	c_irq: cover property (@(posedge mclk_i) $rose(irq_o));

endmodule : io_settings

`default_nettype wire

/* verilog/io_settings_pkg.sv */
// Package for the input polarity and overheat select block.
// Assumes a Wishbone classic slave with 32-bit data on word-aligned offsets.
package io_settings_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_POLARITY = 8'h00;
	localparam logic [7:0] OFS_CHECK_TIME = 8'h04;
	localparam logic [7:0] OFS_OH_SELECT = 8'h08;
	localparam logic [7:0] OFS_TRIP_TEMP = 8'h0c;
	localparam logic [7:0] OFS_APP_CTRL = 8'h10;
	localparam logic [7:0] OFS_RELAY_SEL = 8'h14;
	localparam logic [7:0] OFS_INPUT_STATE = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
	// ------------------------------------------------------------
	// Widths, fields and reset values
	// ------------------------------------------------------------
	localparam int NUM_INPUTS = 11;
	localparam int NUM_BASE = 8;
	localparam int NUM_RELAYS = 4;
	localparam int RELAY_FN_W = 4;
	localparam logic [10:0] POLARITY_RESET = 11'h000;
	localparam logic [2:0] OH_SELECT_RESET = 3'h7;
	localparam int OH_MOTOR_BIT = 0;
	localparam int OH_THERM_BIT = 2;
	localparam logic [7:0] TRIP_TEMP_RESET = 8'h6e;
	localparam logic [7:0] CHECK_MS_RESET = 8'h01;
	localparam logic [3:0] RELAY_FN_MULTI_MOTOR = 4'h9;
	localparam int APP_MULTI_BIT = 0;
	localparam int APP_PROC_BIT = 1;
	localparam int APP_AUXCNT_LSB = 4;
	localparam int IRQ_W = 3;
	localparam int IRQ_MOTOR_TRIP = 0;
	localparam int IRQ_DRIVE_TRIP = 1;
	localparam int IRQ_INPUT_CHANGE = 2;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int CHECK_UNIT_US = 1000;
	localparam int CYCLES_PER_MS = CLK_HZ / 1_000_000 * CHECK_UNIT_US;
endpackage : io_settings_pkg
